// ===== uie_defs.svh
`ifndef UIE_DEFS_SVH
`define UIE_DEFS_SVH
// Register addresses on the three-bit register port.
`define UIE_A_DATA 3'h0
`define UIE_A_MASK 3'h1
`define UIE_A_ISR 3'h2
`define UIE_A_EFC 3'h2
`define UIE_A_LCR 3'h3
`define UIE_A_MCR 3'h4
`define UIE_A_LSR 3'h5
`define UIE_A_MSR 3'h6
`define UIE_A_RES1 3'h4
`define UIE_A_RES2 3'h5
`define UIE_A_PAU1 3'h6
`define UIE_A_PAU2 3'h7
// Key value of the line format register that opens the enhanced bank.
`define UIE_LCR_KEY 8'hbf
// Field positions.
`define UIE_EFC_ENH 4
`define UIE_LCR_DLAB 7
`define UIE_FCR_EN 0
// Reset values.
`define UIE_RST_BYTE 8'h00
// Interrupt source codes, bits 5..0.
`define UIE_ID_LINE 6'h06
`define UIE_ID_TMO 6'h0c
`define UIE_ID_RXD 6'h04
`define UIE_ID_TXR 6'h02
`define UIE_ID_MDM 6'h00
`define UIE_ID_XOFF 6'h10
`define UIE_ID_FLOW 6'h20
`define UIE_ID_NONE 6'h01
// Receive timeout: four characters plus twelve bits, counted in bit times.
`define UIE_TMO_CHARS 4
`define UIE_TMO_BITS 12
`endif

// ===== uie_pkg.sv
package uie_pkg;
   typedef enum logic [2:0] {uie_src_none, uie_src_line, uie_src_tmo, uie_src_rxd, uie_src_txr, uie_src_mdm,
      uie_src_xoff, uie_src_flow} uie_src_e;
   typedef logic [7:0] uie_byte_t;
endpackage

// ===== uie_prio_if.sv
`timescale 1ns/1ps
interface uie_prio_if;
   logic [6:0] pend;
   uie_pkg::uie_src_e src;
   modport ctl (output pend, input src);
   modport pri (input pend, output src);
endinterface

// ===== uie_prio.sv
`timescale 1ns/1ps
module uie_prio
(
   uie_prio_if.pri p
);
   // Fixed priority: line, timeout, data, transmit, modem, xoff, flow change.
   assign p.src = p.pend[0] ? uie_pkg::uie_src_line :
                  p.pend[1] ? uie_pkg::uie_src_tmo :
                  p.pend[2] ? uie_pkg::uie_src_rxd :
                  p.pend[3] ? uie_pkg::uie_src_txr :
                  p.pend[4] ? uie_pkg::uie_src_mdm :
                  p.pend[5] ? uie_pkg::uie_src_xoff :
                  p.pend[6] ? uie_pkg::uie_src_flow : uie_pkg::uie_src_none;
endmodule // uie_prio

// ===== uie_top.sv
`timescale 1ns/1ps
`include "uie_defs.svh"
// Behaviour
// - Enhanced enable bit 4 unlocks upper mask, status, fifo-control and modem-control bits.
// - Enhanced bank reachable only while line format register holds 0xBF.
// - FIFO receive interrupt raised at trigger level, dropped below it.
// - Status bit 2 shows receive level while trigger reached.
// - Data-ready set on character into FIFO, cleared when FIFO empty.
// - FIFO enabled with mask bits 0-3 clear gives polled mode.
// - Line status bit 1 flags receive overrun.
// - Line status bits 2-4 give error kind of head character.
// - Bit 5 transmit FIFO empty; bit 6 FIFO and shift register empty.
// - Bit 7 set while any FIFO character carries an error tag.
// - Non-FIFO mode raises data interrupt while holding register has data.
// - Transmit interrupt on FIFO becoming empty, or at enable if empty.
// - Line interrupt while any of line status bits 1-4 set.
// - Overrun interrupts at reception; other errors while at the head, latched at read out.
// - Mask bit 3 gates modem status interrupt.
// - Mask bit 4 enables sleep mode, only with enhanced bit set.
// - Mask bit 5 gates Xoff receive interrupt, enhanced only.
// - Mask bit 6 or 7 gates interrupt on RTS output rising.
// - Mask bit 7 or 6 gates interrupt on CTS input rising.
// - All mask bits reset to zero.
// - Status read returns only the highest pending source.
// - Source codes as listed, 000001 when nothing pends.
// - Receive timeout after four characters plus twelve bit times idle.
module uie_top
#(
   parameter int FIFO_DEPTH = 16,
   parameter int BITS_PER_CHAR = 10
)
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [2:0] addr,
   input wire logic cs,
   input wire logic rd,
   input wire logic wr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic irq,
   output logic sleep_en,
   output logic [7:0] fifo_control_q,
   output logic [7:0] line_format_control_q,
   output logic [7:0] modem_control_q,
   output logic [7:0] enhanced_feature_control_q,
   output logic [7:0] flow_resume_char_one_q,
   output logic [7:0] flow_resume_char_two_q,
   output logic [7:0] flow_pause_char_one_q,
   output logic [7:0] flow_pause_char_two_q,
   output logic data_write,
   output logic data_read,
   input wire logic [4:0] rx_level,
   input wire logic [4:0] rx_trigger,
   input wire logic rx_push,
   input wire logic rx_overrun,
   input wire logic [2:0] head_err,
   input wire logic any_err_tag,
   input wire logic tx_fifo_empty,
   input wire logic tx_shift_empty,
   input wire logic bit_tick,
   input wire logic [3:0] modem_delta,
   input wire logic [3:0] modem_in,
   input wire logic xoff_seen,
   input wire logic xon_seen,
   input wire logic rts_out,
   input wire logic cts_pin
);
   localparam int TMO_BITS = `UIE_TMO_CHARS * BITS_PER_CHAR + `UIE_TMO_BITS;
   // Refused at elaboration: the level port is five bits wide and the idle counter seven.
   if (FIFO_DEPTH < 1 || FIFO_DEPTH > 31 || BITS_PER_CHAR < 7 || BITS_PER_CHAR > 12)
   begin : g_param_check
      $error("uie_top: unsupported parameters");
   end

   // Reset release through two flops.
   logic rst_m, rst_n;
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   // The CTS pin input is synchronised before any logic reads it.
   logic cts_s1, cts_s2, cts_d;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cts_s1 <= 1'b1;
         cts_s2 <= 1'b1;
         cts_d <= 1'b1;
      end
      else
      begin
         cts_s1 <= cts_pin;
         cts_s2 <= cts_s1;
         cts_d <= cts_s2;
      end
   end

   // Access strobes; the enhanced bank hides the standard ones at shared addresses.
   logic key_open, dlab, enh, fifo_on;
   assign key_open = (line_format_control_q == `UIE_LCR_KEY);
   assign dlab = line_format_control_q[`UIE_LCR_DLAB];
   assign enh = enhanced_feature_control_q[`UIE_EFC_ENH];
   assign fifo_on = fifo_control_q[`UIE_FCR_EN];
   function automatic logic hit(input logic [2:0] a, input logic [2:0] want, input logic s);
      hit = s && (a == want);
   endfunction
   logic w_mask, w_fcr, w_lcr, w_mcr, w_efc, w_r1, w_r2, w_p1, w_p2, w_thr;
   logic r_isr, r_lsr, r_msr, r_rhr;
   assign w_thr = hit(addr, `UIE_A_DATA, cs && wr && !dlab && !key_open);
   assign w_mask = hit(addr, `UIE_A_MASK, cs && wr && !dlab && !key_open);
   assign w_fcr = hit(addr, `UIE_A_ISR, cs && wr && !key_open);
   assign w_lcr = hit(addr, `UIE_A_LCR, cs && wr);
   assign w_mcr = hit(addr, `UIE_A_MCR, cs && wr && !key_open);
   assign w_efc = hit(addr, `UIE_A_EFC, cs && wr && key_open);
   assign w_r1 = hit(addr, `UIE_A_RES1, cs && wr && key_open);
   assign w_r2 = hit(addr, `UIE_A_RES2, cs && wr && key_open);
   assign w_p1 = hit(addr, `UIE_A_PAU1, cs && wr && key_open);
   assign w_p2 = hit(addr, `UIE_A_PAU2, cs && wr && key_open);
   assign r_rhr = hit(addr, `UIE_A_DATA, cs && rd && !dlab && !key_open);
   assign r_isr = hit(addr, `UIE_A_ISR, cs && rd && !key_open);
   assign r_lsr = hit(addr, `UIE_A_LSR, cs && rd && !key_open);
   assign r_msr = hit(addr, `UIE_A_MSR, cs && rd && !key_open);

   // Masked write values: upper bits, except FIFO-control bits 7:6, only stick with enhanced functions on.
   logic [7:0] interrupt_mask_q, mask_d, fcr_d, mcr_d;
   assign mask_d = enh ? wdata : {4'h0, wdata[3:0]};
   assign fcr_d = enh ? wdata : {wdata[7:6], 2'h0, wdata[3:0]};
   assign mcr_d = enh ? wdata : {3'h0, wdata[4:0]};

   // Configuration registers; all clear at reset.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         interrupt_mask_q <= `UIE_RST_BYTE;
         fifo_control_q <= `UIE_RST_BYTE;
         line_format_control_q <= `UIE_RST_BYTE;
         modem_control_q <= `UIE_RST_BYTE;
         enhanced_feature_control_q <= `UIE_RST_BYTE;
         flow_resume_char_one_q <= `UIE_RST_BYTE;
         flow_resume_char_two_q <= `UIE_RST_BYTE;
         flow_pause_char_one_q <= `UIE_RST_BYTE;
         flow_pause_char_two_q <= `UIE_RST_BYTE;
      end
      else
      begin
         if (w_mask) interrupt_mask_q <= mask_d;
         // FIFO reset bits self-clear; other bits only program with the enable set.
         if (w_fcr) fifo_control_q <= wdata[`UIE_FCR_EN] ? {fcr_d[7:3], 2'h0, 1'b1} : `UIE_RST_BYTE;
         if (w_lcr) line_format_control_q <= wdata;
         if (w_mcr) modem_control_q <= mcr_d;
         if (w_efc) enhanced_feature_control_q <= wdata;
         if (w_r1) flow_resume_char_one_q <= wdata;
         if (w_r2) flow_resume_char_two_q <= wdata;
         if (w_p1) flow_pause_char_one_q <= wdata;
         if (w_p2) flow_pause_char_two_q <= wdata;
      end
   end

   // Effective enables; upper ones also need the enhanced bit now.
   logic [7:0] en;
   assign en = enh ? interrupt_mask_q : {4'h0, interrupt_mask_q[3:0]};

   // Line status view.
   logic ovr_q, rx_ready, rx_trig;
   logic [7:0] line_status;
   assign rx_ready = (rx_level != 5'h00);
   assign rx_trig = fifo_on ? (rx_level >= rx_trigger) : rx_ready;
   assign line_status = {any_err_tag && fifo_on,
                 tx_fifo_empty && tx_shift_empty, tx_fifo_empty,
                 head_err,
                 ovr_q,
                 rx_ready};

   // Sticky events: a new event wins over the clear in the same cycle.
   logic line_q, txr_q, tmo_q, xoff_q, flow_q, rts_d, mask1_d, tx_empty_d;
   logic src_is_txr, src_is_xoff;
   logic tx_rise, rts_rise, cts_rise, line_ev;
   assign tx_rise = tx_fifo_empty && !tx_empty_d;
   assign rts_rise = rts_out && !rts_d;
   assign cts_rise = cts_s2 && !cts_d;
   assign line_ev = rx_overrun || (r_rhr && (head_err != 3'h0));
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ovr_q <= 1'b0;
         line_q <= 1'b0;
         txr_q <= 1'b0;
         xoff_q <= 1'b0;
         flow_q <= 1'b0;
         rts_d <= 1'b0;
         mask1_d <= 1'b0;
         tx_empty_d <= 1'b1; // An empty FIFO at reset release is no fresh edge.
      end
      else
      begin
         rts_d <= rts_out;
         mask1_d <= en[1];
         tx_empty_d <= tx_fifo_empty;
         ovr_q <= rx_overrun || (ovr_q && !r_lsr);
         line_q <= line_ev || (line_q && !r_lsr);
         // Transmit ready on becoming empty or on enabling while empty.
         txr_q <= (tx_fifo_empty && (tx_rise || (en[1] && !mask1_d))) ||
                  (txr_q && tx_fifo_empty && !(r_isr && src_is_txr) && !w_thr);
         xoff_q <= xoff_seen || (xoff_q && !(r_isr && src_is_xoff) && !xon_seen);
         flow_q <= (rts_rise && enhanced_feature_control_q[6]) ||
                   (cts_rise && enhanced_feature_control_q[7]) || (flow_q && !r_msr);
      end
   end

   // Receive timeout: bit times without FIFO activity while data waits.
   logic [6:0] idle_q;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         idle_q <= 7'h00;
         tmo_q <= 1'b0;
      end
      else
      begin
         if (rx_push || r_rhr || !rx_ready || !fifo_on)
            idle_q <= 7'h00;
         else if (bit_tick && idle_q != TMO_BITS[6:0])
            idle_q <= idle_q + 7'h01;
         tmo_q <= (bit_tick && idle_q == TMO_BITS[6:0] - 7'h01) || (tmo_q && !r_rhr && rx_ready);
      end
   end

   // Pending sources gated by their enables.
   uie_prio_if pi();
   assign pi.pend = {flow_q && (en[6] || en[7]),
                     xoff_q && en[5],
                     (modem_delta != 4'h0) && en[3],
                     txr_q && en[1],
                     rx_trig && en[0],
                     tmo_q && en[0],
                     (line_status[4:1] != 4'h0 || line_q) && en[2]};
   uie_prio u_prio (.p(pi.pri));
   assign src_is_txr = (pi.src == uie_pkg::uie_src_txr);
   assign src_is_xoff = (pi.src == uie_pkg::uie_src_xoff);

   // Source code for the status register.
   logic [5:0] code;
   always_comb
   begin
      case (pi.src)
         uie_pkg::uie_src_line: code = `UIE_ID_LINE;
         uie_pkg::uie_src_tmo: code = `UIE_ID_TMO;
         uie_pkg::uie_src_rxd: code = `UIE_ID_RXD;
         uie_pkg::uie_src_txr: code = `UIE_ID_TXR;
         uie_pkg::uie_src_mdm: code = `UIE_ID_MDM;
         uie_pkg::uie_src_xoff: code = enh ? `UIE_ID_XOFF : `UIE_ID_NONE;
         uie_pkg::uie_src_flow: code = enh ? `UIE_ID_FLOW : `UIE_ID_NONE;
         default: code = `UIE_ID_NONE;
      endcase
   end

   // Read mux, registered; polled mode simply reads line status with masks clear.
   logic [7:0] rd_mux;
   assign rd_mux = key_open ?
                   (addr == `UIE_A_EFC ? enhanced_feature_control_q :
                    addr == `UIE_A_RES1 ? flow_resume_char_one_q :
                    addr == `UIE_A_RES2 ? flow_resume_char_two_q :
                    addr == `UIE_A_PAU1 ? flow_pause_char_one_q :
                    addr == `UIE_A_PAU2 ? flow_pause_char_two_q :
                    addr == `UIE_A_LCR ? line_format_control_q : `UIE_RST_BYTE) :
                   (addr == `UIE_A_MASK && !dlab ? interrupt_mask_q :
                    addr == `UIE_A_ISR ? {fifo_on, fifo_on, code} :
                    addr == `UIE_A_LCR ? line_format_control_q :
                    addr == `UIE_A_MCR ? modem_control_q :
                    addr == `UIE_A_LSR ? line_status :
                    addr == `UIE_A_MSR ? {modem_in, modem_delta} : `UIE_RST_BYTE);

   // Registered outputs.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata <= `UIE_RST_BYTE;
         irq <= 1'b0;
         sleep_en <= 1'b0;
         data_write <= 1'b0;
         data_read <= 1'b0;
      end
      else
      begin
         if (cs && rd) rdata <= rd_mux;
         irq <= (pi.src != uie_pkg::uie_src_none);
         sleep_en <= en[4];
         data_write <= w_thr;
         data_read <= r_rhr;
      end
   end
endmodule // uie_top

// ===== uie_top_asserts.sv
`timescale 1ns/1ps
`include "uie_defs.svh"
// Watches the register port and the status outputs of the top level.
module uie_chk
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [2:0] addr,
   input wire logic cs,
   input wire logic rd,
   input wire logic wr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic irq,
   input wire logic sleep_en,
   input wire logic [7:0] fifo_control_q,
   input wire logic [7:0] line_format_control_q,
   input wire logic [7:0] enhanced_feature_control_q,
   input wire logic [7:0] flow_resume_char_one_q,
   input wire logic tx_fifo_empty,
   input wire logic tx_shift_empty,
   input wire logic any_err_tag
);
   // Access decodes; the key value hides status and line registers behind the enhanced bank.
   wire key_open = line_format_control_q == `UIE_LCR_KEY;
   wire rd_isr = cs && rd && addr == 3'h2 && !key_open;
   wire rd_lsr = cs && rd && addr == 3'h5 && !key_open;
   wire wr_key = cs && wr && key_open;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Read answers are registered, so the fifo, transmit and error checks use $past inputs from the read edge; irq, registered alongside, is compared as is.
   chk_efc_write: assert property (wr_key && addr == 3'h2 |=> enhanced_feature_control_q == $past(wdata))
      else $error("enhanced feature write lost");
   chk_bank_locked: assert property (cs && wr && addr == 3'h4 && !key_open |=> $stable(flow_resume_char_one_q))
      else $error("flow character written while bank closed");
   chk_sleep_gate: assert property (sleep_en |-> $past(enhanced_feature_control_q[4]))
      else $error("sleep enabled without enhanced bit");
   chk_fifo_status: assert property (rd_isr |=> rdata[7:6] == {2{$past(fifo_control_q[0])}})
      else $error("fifo enable bits wrong in status");
   chk_status_irq: assert property (rd_isr |=> rdata[0] == !irq)
      else $error("status pending bit disagrees with irq");
   chk_idle_code: assert property (rd_isr |=> rdata[0] == (rdata[5:0] == `UIE_ID_NONE))
      else $error("bad idle source code");
   chk_upper_isr: assert property (rd_isr && !enhanced_feature_control_q[4] |=> rdata[5:4] == 2'b00)
      else $error("upper status bits without enhanced bit");
   chk_line_tx: assert property (rd_lsr |=> rdata[6:5] == {$past(tx_fifo_empty) && $past(tx_shift_empty),
      $past(tx_fifo_empty)})
      else $error("transmit empty bits wrong");
   chk_error_flag: assert property (rd_lsr |=> rdata[7] == ($past(any_err_tag) && $past(fifo_control_q[0])))
      else $error("global error bit wrong");
   cov_pending: cover property (rd_isr && irq);
   cov_sleep: cover property ($rose(sleep_en));
   cov_bank: cover property (wr_key && addr == 3'h7);
endmodule // uie_chk

bind uie_top uie_chk u_chk (.mclk(mclk), .resetn(resetn), .addr(addr), .cs(cs), .rd(rd), .wr(wr),
   .wdata(wdata), .rdata(rdata), .irq(irq), .sleep_en(sleep_en), .fifo_control_q(fifo_control_q),
   .line_format_control_q(line_format_control_q), .enhanced_feature_control_q(enhanced_feature_control_q),
   .flow_resume_char_one_q(flow_resume_char_one_q), .tx_fifo_empty(tx_fifo_empty),
   .tx_shift_empty(tx_shift_empty), .any_err_tag(any_err_tag));

// ===== uie_host.sv
`timescale 1ns/1ps
// Host on the register port; each access is one strobe cycle and one idle cycle.
module uie_host
(
   input wire logic mclk,
   input wire logic [7:0] rdata,
   output logic [2:0] addr,
   output logic cs,
   output logic rd,
   output logic wr,
   output logic [7:0] wdata
);
   // The bus idles with no strobe.
   initial
   begin
      addr = 3'h0;
      wdata = 8'h00;
      cs = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
   end
   // Released lines show inverted values so that a design latching late sees garbage.
   task wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(negedge mclk);
      addr = a;
      wdata = d;
      cs = 1'b1;
      wr = 1'b1;
      @(negedge mclk);
      cs = 1'b0;
      wr = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask
   // Read data is registered, so it is taken one falling edge after the strobe.
   task rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(negedge mclk);
      addr = a;
      cs = 1'b1;
      rd = 1'b1;
      @(negedge mclk);
      cs = 1'b0;
      rd = 1'b0;
      addr = ~a;
      d = rdata;
   endtask
endmodule // uie_host

// ===== uart_interrupt_enable_status_bench.sv
`timescale 1ns/1ps
module uart_interrupt_enable_status_bench;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] addr;
   logic cs, rd, wr, irq, sleep_en, dwr, drd;
   logic [7:0] wdata, rdata, v, r1q, p2q, mcq, fcq;
   logic [4:0] rx_level = 5'h00, rx_trigger = 5'h00;
   logic rx_push = 1'b0, rx_overrun = 1'b0, any_err_tag = 1'b0, tx_fifo_empty = 1'b0, tx_shift_empty = 1'b0;
   logic bit_tick = 1'b0, xoff_seen = 1'b0, xon_seen = 1'b0, rts_out = 1'b0, cts_pin = 1'b0;
   logic [2:0] head_err = 3'h0;
   logic [3:0] modem_delta = 4'h0, modem_in = 4'h0;
   int bad_count = 0;
   int compares = 0;
   uie_host host (.mclk(mclk), .rdata(rdata), .addr(addr), .cs(cs), .rd(rd), .wr(wr), .wdata(wdata));
   uie_top #(.FIFO_DEPTH(16), .BITS_PER_CHAR(7)) DUT (.mclk(mclk), .resetn(resetn), .addr(addr), .cs(cs),
      .rd(rd), .wr(wr), .wdata(wdata), .rdata(rdata), .irq(irq), .sleep_en(sleep_en), .fifo_control_q(fcq),
      .line_format_control_q(), .modem_control_q(mcq), .enhanced_feature_control_q(), .flow_resume_char_one_q(r1q),
      .flow_resume_char_two_q(), .flow_pause_char_one_q(), .flow_pause_char_two_q(p2q), .data_write(dwr),
      .data_read(drd), .rx_level(rx_level), .rx_trigger(rx_trigger), .rx_push(rx_push), .rx_overrun(rx_overrun),
      .head_err(head_err), .any_err_tag(any_err_tag), .tx_fifo_empty(tx_fifo_empty),
      .tx_shift_empty(tx_shift_empty), .bit_tick(bit_tick), .modem_delta(modem_delta), .modem_in(modem_in),
      .xoff_seen(xoff_seen), .xon_seen(xon_seen), .rts_out(rts_out), .cts_pin(cts_pin));
   // A 40 ns clock.
   always #20 mclk = ~mclk;
   task check(input string n, input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task rdc(input logic [2:0] a, input logic [7:0] e, input string n);
      host.rd_reg(a, v);
      check(n, v, e);
   endtask
   // Lets registered status and the synchronised pin settle before looking.
   task settle;
      repeat (3) @(negedge mclk);
   endtask
   task tally_and_finish;
      if (bad_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // The sequence needs a few hundred cycles; far beyond that means a hang.
   initial
   begin
      #100000;
      bad_count++;
      tally_and_finish();
   end
   // Main sequence; inputs change only at falling edges.
   initial
   begin
      repeat (4) @(negedge mclk);
      resetn = 1'b1;
      repeat (3) @(negedge mclk);
      rdc(3'h1, 8'h00, "mask");
      host.wr_reg(3'h1, 8'hff);
      rdc(3'h1, 8'h0f, "mask");
      host.wr_reg(3'h1, 8'h00);
      host.wr_reg(3'h3, 8'hbf);
      host.wr_reg(3'h2, 8'hd0);
      host.wr_reg(3'h4, 8'h11);
      host.wr_reg(3'h7, 8'h13);
      rdc(3'h2, 8'hd0, "efc");
      rdc(3'h4, 8'h11, "resume");
      check("pause", p2q, 8'h13);
      host.wr_reg(3'h3, 8'h03);
      host.wr_reg(3'h4, 8'h5a);
      check("mcr", mcq, 8'h5a);
      check("resume", r1q, 8'h11);
      host.wr_reg(3'h1, 8'h10);
      settle();
      check("sleep", 8'(sleep_en), 8'h01);
      tx_fifo_empty = 1'b1;
      host.wr_reg(3'h1, 8'h02);
      settle();
      check("irq", 8'(irq), 8'h01);
      rdc(3'h2, 8'h02, "isr");
      settle();
      check("irq", 8'(irq), 8'h00);
      tx_fifo_empty = 1'b0;
      settle();
      tx_fifo_empty = 1'b1;
      settle();
      check("irq", 8'(irq), 8'h01);
      host.wr_reg(3'h0, 8'h55);
      check("thr write", 8'(dwr), 8'h01);
      settle();
      check("irq", 8'(irq), 8'h00);
      rx_level = 5'h01;
      host.wr_reg(3'h1, 8'h01);
      settle();
      rdc(3'h2, 8'h04, "isr");
      rx_trigger = 5'h04;
      rx_level = 5'h04;
      host.wr_reg(3'h2, 8'h37);
      check("fcr", fcq, 8'h31);
      host.wr_reg(3'h1, 8'h03);
      settle();
      rdc(3'h2, 8'hc4, "isr");
      rx_level = 5'h03;
      settle();
      rdc(3'h2, 8'hc2, "isr");
      settle();
      check("irq", 8'(irq), 8'h00);
      any_err_tag = 1'b1;
      settle();
      rdc(3'h5, 8'ha1, "lsr");
      tx_shift_empty = 1'b1;
      any_err_tag = 1'b0;
      rx_level = 5'h00;
      settle();
      rdc(3'h5, 8'h60, "lsr");
      rx_level = 5'h01;
      host.wr_reg(3'h1, 8'h04);
      rx_overrun = 1'b1;
      @(negedge mclk);
      rx_overrun = 1'b0;
      settle();
      rdc(3'h2, 8'hc6, "isr");
      rdc(3'h5, 8'h63, "lsr");
      settle();
      check("irq", 8'(irq), 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         head_err = 3'h1 << i;
         settle();
         rdc(3'h5, {3'b011, head_err, 2'b01}, "lsr");
         check("irq", 8'(irq), 8'h01);
      end
      // Reading out the flawed head character latches the line interrupt past the error itself.
      host.rd_reg(3'h0, v);
      check("rhr read", 8'(drd), 8'h01);
      head_err = 3'h0;
      settle();
      check("irq", 8'(irq), 8'h01);
      rdc(3'h2, 8'hc6, "isr");
      rdc(3'h5, 8'h61, "lsr");
      settle();
      check("irq", 8'(irq), 8'h00);
      host.wr_reg(3'h1, 8'h00);
      modem_delta = 4'h1;
      settle();
      check("irq", 8'(irq), 8'h00);
      host.wr_reg(3'h1, 8'h08);
      settle();
      rdc(3'h2, 8'hc0, "isr");
      modem_delta = 4'h0;
      host.wr_reg(3'h1, 8'h20);
      xoff_seen = 1'b1;
      @(negedge mclk);
      xoff_seen = 1'b0;
      settle();
      rdc(3'h2, 8'hd0, "isr");
      settle();
      check("irq", 8'(irq), 8'h00);
      host.wr_reg(3'h1, 8'h40);
      rts_out = 1'b1;
      settle();
      rdc(3'h2, 8'he0, "isr");
      host.rd_reg(3'h6, v);
      host.wr_reg(3'h1, 8'h80);
      cts_pin = 1'b1;
      settle();
      settle();
      rdc(3'h2, 8'he0, "isr");
      host.rd_reg(3'h6, v);
      host.wr_reg(3'h1, 8'h01);
      // Four characters of seven bits plus twelve bits make forty bit times of silence.
      bit_tick = 1'b1;
      repeat (39) @(negedge mclk);
      bit_tick = 1'b0;
      settle();
      check("irq", 8'(irq), 8'h00);
      bit_tick = 1'b1;
      @(negedge mclk);
      bit_tick = 1'b0;
      settle();
      rdc(3'h2, 8'hcc, "isr");
      host.rd_reg(3'h0, v);
      settle();
      check("irq", 8'(irq), 8'h00);
      // A second reset in mid-run must clear every enable again.
      host.wr_reg(3'h1, 8'hff);
      resetn = 1'b0;
      repeat (4) @(negedge mclk);
      resetn = 1'b1;
      repeat (3) @(negedge mclk);
      rdc(3'h1, 8'h00, "mask");
      check("sleep", 8'(sleep_en), 8'h00);
      tally_and_finish();
   end
endmodule // uart_interrupt_enable_status_bench
